// ---- verilog/som_pkg.sv ----
// Constants, register map and field layout of the servo overload monitor.
// Assumes one 100 MHz system clock and an APB master with 32-bit data.
package som_pkg;

	localparam int            NUM_AXES       = 8;
	localparam int            CLK_FREQ_MHZ   = 100;
	// Overload sample period, in microseconds
	localparam int            SAMPLE_PERIOD_US = 1000;
	localparam int            SAMPLE_CYCLES  = SAMPLE_PERIOD_US * CLK_FREQ_MHZ;
	// Overload time unit is one sample, i.e. milliseconds
	localparam logic [15:0]   OVL_TIME_RESET = 16'h0bb8;

	// Torque codes: full scale is peak current, continuous is half of it
	localparam logic [15:0]   FULL_SCALE     = 16'h7fff;
	localparam logic [14:0]   CONT_LEVEL     = 15'h4000;

	localparam logic [7:0]    ERR_OVERLOAD   = 8'h1a;
	localparam logic [7:0]    TASK_MASK_RST  = 8'hff;

	// Byte addresses
	localparam logic [7:0]    REG_OVL_TIME   = 8'h00;
	localparam logic [7:0]    REG_ERR_CODE   = 8'h04;
	localparam logic [7:0]    REG_ERR_AXIS   = 8'h08;
	localparam logic [7:0]    REG_STATUS     = 8'h0c;
	localparam logic [7:0]    REG_TASK_MASK  = 8'h10;
	localparam logic [7:0]    REG_INTEG_OPT  = 8'h14;
	localparam logic [7:0]    REG_BULK_CTRL  = 8'h18;
	localparam logic [2:0]    BANK_LIMIT     = 3'h1;
	localparam logic [2:0]    BANK_STAGE     = 3'h2;

	// Status word fields
	localparam int            ST_SAT_LSB     = 0;
	localparam int            ST_TRIP_LSB    = 8;
	localparam int            ST_FOL_LSB     = 16;
	localparam int            ST_TRAP_BIT    = 24;
	// Error word fields
	localparam int            ERR_AXIS_LSB   = 8;

endpackage

// ---- verilog/som_ovl_axis.sv ----
// Amp-second overload accumulator for one axis.
// Assumes a one-cycle sample tick and a magnitude already clamped to full scale.
`timescale 1ns/10ps
module som_ovl_axis
	import som_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        tick,
	input  wire logic [14:0] mag,
	input  wire logic [15:0] time_limit,
	input  wire logic        clr,
	output logic             trip
);

	logic [31:0] acc;
	logic [31:0] threshold;
	logic [31:0] excess;
	logic [31:0] deficit;

	// Threshold is peak/2 times time; peak/2 equals the continuous code
	// threshold from time
	assign threshold = 32'(CONT_LEVEL) * 32'(time_limit);
	assign excess    = (mag > CONT_LEVEL) ? 32'(mag - CONT_LEVEL) : 32'h0000_0000;
	assign deficit   = (mag < CONT_LEVEL) ? 32'(CONT_LEVEL - mag) : 32'h0000_0000;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			acc <= 32'h0000_0000;
		end else if (clr || time_limit == 16'h0000) begin
			acc <= 32'h0000_0000;
		end else if (tick) begin
			if (excess != 32'h0000_0000) begin
				acc <= (acc > ~excess) ? 32'hffff_ffff : acc + excess;
			end else begin
				acc <= (acc > deficit) ? acc - deficit : 32'h0000_0000;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			trip <= 1'b0;
		end else begin
			trip <= (time_limit != 16'h0000) && !clr && (acc >= threshold);
		end
	end

endmodule

// ---- verilog/som_monitor.sv ----
// Eight-axis servo supervision: torque clamp, overload trip, error latch,
// following-error check and integrator gating, with an APB register file.
// Assumes encoder words arrive from pins; all other inputs share clk.
//
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/10ps
module som_monitor
	import som_pkg::*;
#(
	parameter int unsigned SAMPLE_CYCLES_P = som_pkg::SAMPLE_CYCLES
) (
	input  wire logic              clk,
	input  wire logic              rst_b,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic [7:0][17:0]  torque_req,
	input  wire logic [7:0][31:0]  cmd_pos,
	input  wire logic [7:0][31:0]  enc_pos_pin,
	input  wire logic              profile_moving,
	output logic      [7:0][15:0]  torque_cmd,
	output logic      [7:0]        amp_enable,
	output logic      [7:0]        integ_enable,
	output logic      [7:0]        axis_stop,
	output logic      [7:0]        fol_fault,
	output logic                   error_trap
);

	logic [7:0][31:0] enc_meta;
	logic [7:0][31:0] enc_pos;
	logic [15:0]      ovl_time;
	logic [7:0]       err_code;
	logic [3:0]       err_axis;
	logic [7:0]       task_mask;
	logic [7:0]       integ_opt;
	logic [7:0][31:0] fol_limit;
	logic [7:0][31:0] bulk_stage;
	logic [7:0]       bulk_valid;
	logic [7:0]       tripped;
	logic [7:0]       next_tripped;
	logic [7:0]       saturated;
	logic [7:0]       ovl_trip;
	logic [7:0]       new_trip;
	logic [7:0]       fol_over;
	logic [31:0]      tick_cnt;
	logic             tick;
	logic             acc_clr;
	logic             err_clear;
	logic             err_set;
	logic             wr_en;
	logic             rd_phase;
	logic [31:0]      rd_val;
	logic             rd_err;
	logic             bulk_commit;

	function automatic logic [3:0] lowest_axis(input logic [7:0] v);
		logic [3:0] n;
		n = 4'h0;
		for (int k = NUM_AXES - 1; k >= 0; k--) begin
			if (v[k]) begin
				n = 4'(k + 1);
			end
		end
		return n;
	endfunction

	// Encoder words come from another domain; two stages before use
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			enc_meta <= '0;
			enc_pos  <= '0;
		end else begin
			enc_meta <= enc_pos_pin;
			enc_pos  <= enc_meta;
		end
	end

	// Overload sample tick
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			tick_cnt <= 32'h0000_0000;
			tick     <= 1'b0;
		end else if (tick_cnt >= SAMPLE_CYCLES_P - 1) begin
			tick_cnt <= 32'h0000_0000;
			tick     <= 1'b1;
		end else begin
			tick_cnt <= tick_cnt + 32'h0000_0001;
			tick     <= 1'b0;
		end
	end

	// APB access phase: answer one cycle after penable rises
	assign rd_phase = psel && penable && !pready;
	assign wr_en    = psel && penable && pready && pwrite;

	always_comb begin
		rd_val = 32'h0000_0000;
		rd_err = 1'b0;
		if (paddr[1:0] != 2'b00) begin
			rd_err = 1'b1;
		end else if (paddr[7:5] == BANK_LIMIT) begin
			rd_val = fol_limit[paddr[4:2]];
		end else if (paddr[7:5] == BANK_STAGE) begin
			rd_val = bulk_stage[paddr[4:2]];
		end else begin
			case (paddr)
				REG_OVL_TIME:  rd_val = {16'h0000, ovl_time};
				REG_ERR_CODE:  rd_val = {16'h0000, 4'h0, err_axis, err_code};
				REG_ERR_AXIS:  rd_val = {28'h000_0000, err_axis};
				REG_STATUS:    rd_val = {7'h00, error_trap, fol_fault, tripped, saturated};
				REG_TASK_MASK: rd_val = {24'h00_0000, task_mask};
				REG_INTEG_OPT: rd_val = {24'h00_0000, integ_opt};
				REG_BULK_CTRL: rd_val = {24'h00_0000, bulk_valid};
				default:       rd_err = 1'b1;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready  <= rd_phase;
			pslverr <= rd_phase && rd_err;
			if (rd_phase) begin
				prdata <= pwrite ? 32'h0000_0000 : rd_val;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ovl_time <= OVL_TIME_RESET;
		end else if (wr_en && paddr == REG_OVL_TIME) begin
			ovl_time <= pwdata[15:0];
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			task_mask <= TASK_MASK_RST;
			integ_opt <= 8'h00;
		end else if (wr_en && paddr == REG_TASK_MASK) begin
			task_mask <= pwdata[7:0];
		end else if (wr_en && paddr == REG_INTEG_OPT) begin
			integ_opt <= pwdata[7:0];
		end
	end

	// staged list, only filled slots commit
	assign bulk_commit = wr_en && paddr == REG_BULK_CTRL;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			bulk_stage <= '0;
			bulk_valid <= 8'h00;
		end else begin
			for (int a = 0; a < NUM_AXES; a++) begin
				if (wr_en && paddr[7:5] == BANK_STAGE && paddr[4:2] == 3'(a)) begin
					bulk_stage[a] <= pwdata;
					bulk_valid[a] <= 1'b1;
				end else if (bulk_commit) begin
					bulk_valid[a] <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			fol_limit <= '0;
		end else begin
			for (int a = 0; a < NUM_AXES; a++) begin
				if (wr_en && paddr[7:5] == BANK_LIMIT && paddr[4:2] == 3'(a)) begin
					fol_limit[a] <= pwdata;
				end else if (bulk_commit && bulk_valid[a]) begin
					fol_limit[a] <= bulk_stage[a];
				end
			end
		end
	end

	// pair zero, zero clears the latch
	assign err_clear = wr_en && paddr == REG_ERR_CODE && pwdata[15:0] == 16'h0000;
	assign acc_clr   = err_clear;
	assign new_trip  = ovl_trip & ~tripped;
	// First trip after a clear owns the latch; a trip in the clear cycle wins
	assign err_set   = (new_trip != 8'h00) && (err_code == 8'h00 || err_clear);

	always_comb begin
		next_tripped = err_clear ? 8'h00 : tripped;
		next_tripped = next_tripped | new_trip;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			tripped    <= 8'h00;
			amp_enable <= 8'h00;
		end else begin
			tripped    <= next_tripped;
			amp_enable <= ~next_tripped;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			err_code <= 8'h00;
			err_axis <= 4'h0;
		end else if (err_set) begin
			err_code <= ERR_OVERLOAD;
			err_axis <= lowest_axis(new_trip);
		end else if (err_clear) begin
			err_code <= 8'h00;
			err_axis <= 4'h0;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			error_trap <= 1'b0;
			axis_stop  <= 8'h00;
		end else if (new_trip != 8'h00) begin
			error_trap <= 1'b1;
			axis_stop  <= task_mask;
		end else if (err_clear) begin
			error_trap <= 1'b0;
			axis_stop  <= 8'h00;
		end
	end

	// integrator held during motion when selected
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			integ_enable <= 8'hff;
		end else begin
			integ_enable <= ~(integ_opt & {NUM_AXES{profile_moving}});
		end
	end

	// Sticky following fault; a new event outranks software clear
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			fol_fault <= 8'h00;
		end else begin
			for (int a = 0; a < NUM_AXES; a++) begin
				if (fol_over[a]) begin
					fol_fault[a] <= 1'b1;
				end else if (wr_en && paddr == REG_STATUS && pwdata[ST_FOL_LSB + a]) begin
					fol_fault[a] <= 1'b0;
				end
			end
		end
	end

	for (genvar g = 0; g < NUM_AXES; g++) begin : g_axis
		logic signed [17:0] req;
		logic signed [17:0] full_pos;
		logic signed [17:0] full_neg;
		logic        [15:0] clamped;
		logic        [14:0] mag;
		logic signed [31:0] pos_err;
		logic        [31:0] err_mag;

		assign req      = $signed(torque_req[g]);
		assign full_pos = $signed({2'b00, FULL_SCALE});
		assign full_neg = -full_pos;

		always_comb begin
			if (req > full_pos) begin
				clamped = FULL_SCALE;
			end else if (req < full_neg) begin
				clamped = 16'(full_neg);
			end else begin
				clamped = req[15:0];
			end
		end

		always_ff @(posedge clk or negedge rst_b) begin
			if (!rst_b) begin
				torque_cmd[g] <= 16'h0000;
				saturated[g]  <= 1'b0;
			end else if (next_tripped[g]) begin
				torque_cmd[g] <= 16'h0000;
				saturated[g]  <= 1'b0;
			end else begin
				torque_cmd[g] <= clamped;
				saturated[g]  <= (req >= full_pos) || (req <= full_neg);
			end
		end

		// magnitude is linear in command code
		assign mag = torque_cmd[g][15] ? 15'(-$signed(torque_cmd[g])) : torque_cmd[g][14:0];

		som_ovl_axis u_ovl (
			.clk        (clk),
			.rst_b      (rst_b),
			.tick       (tick),
			.mag        (mag),
			.time_limit (ovl_time),
			.clr        (acc_clr),
			.trip       (ovl_trip[g])
		);

		assign pos_err = $signed(cmd_pos[g]) - $signed(enc_pos[g]);
		assign err_mag = pos_err[31] ? 32'(-pos_err) : 32'(pos_err);
		assign fol_over[g] = profile_moving && (err_mag > fol_limit[g]);
	end

endmodule

// ---- test/som_amp_model.sv ----
// Amplifier and encoder stand-in for the servo overload monitor.
// Assumes the bench sets the tracking lag; shares the system clock.
`timescale 1ns/10ps
module som_amp_model (
	input  wire logic             clk,
	input  wire logic             rst_b,
	input  wire logic [7:0]       amp_enable,
	input  wire logic [7:0][31:0] cmd_pos,
	input  wire logic [31:0]      lag,
	output logic      [7:0][31:0] enc_pos_pin
);
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			enc_pos_pin <= '0;
		end else begin
			for (int i = 0; i < 8; i++) begin
				if (amp_enable[i]) begin
					enc_pos_pin[i] <= cmd_pos[i] - lag;
				end else begin
					enc_pos_pin[i] <= enc_pos_pin[i] + 32'h1;
				end
			end
		end
	end
endmodule

// ---- test/som_monitor_checker.sv ----
// Port-level checks of the servo overload monitor.
// Assumes the single clk domain and rst_b of the top module.
`timescale 1ns/10ps
module som_monitor_checker #(
	parameter int unsigned SAMPLE_CYCLES_P = 8
) (
	input  wire logic             clk,
	input  wire logic             rst_b,
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pready,
	input  wire logic             pslverr,
	input  wire logic [7:0][17:0] torque_req,
	input  wire logic             profile_moving,
	input  wire logic [7:0][15:0] torque_cmd,
	input  wire logic [7:0]       amp_enable,
	input  wire logic [7:0]       integ_enable,
	input  wire logic [7:0]       axis_stop,
	input  wire logic [7:0]       fol_fault,
	input  wire logic             error_trap
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	a_clamp_high: assert property (amp_enable[0] && $signed(torque_req[0]) > 32767
		|=> torque_cmd[0] == 16'h7fff || !amp_enable[0]) else $error("clamp high");
	a_clamp_low: assert property (amp_enable[0] && $signed(torque_req[0]) < -32767
		|=> torque_cmd[0] == 16'h8001 || !amp_enable[0]) else $error("clamp low");
	// Axis 2 is the one the bench drives into overload
	a_trip_traps: assert property ($fell(amp_enable[2]) |-> error_trap)
		else $error("disable without trap");
	a_off_silent: assert property (!amp_enable[2] |-> torque_cmd[2] == 16'h0)
		else $error("command while disabled");
	a_stop_with_trap: assert property (!error_trap |-> axis_stop == 8'h00)
		else $error("stop without trap");
	a_trap_disables: assert property ($rose(error_trap) |-> amp_enable != 8'hff)
		else $error("trap with no axis off");
	a_integ_idle: assert property (!profile_moving |=> integ_enable == 8'hff)
		else $error("integrator held at rest");
	a_fault_motion: assert property ($rose(fol_fault[0])
		|-> $past(profile_moving) || $past(profile_moving, 2)) else $error("fault at rest");
	a_ready_wait: assert property (psel && penable && !pready |=> pready [*1] ##1 !pready)
		else $error("ready timing");
	a_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
	c_trip: cover property ($rose(error_trap));
	c_fault: cover property ($rose(fol_fault[0]));
	c_refused: cover property (pslverr);
endmodule

bind som_monitor som_monitor_checker #(.SAMPLE_CYCLES_P(SAMPLE_CYCLES_P)) chk_i (
	.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pready(pready),
	.pslverr(pslverr), .torque_req(torque_req), .profile_moving(profile_moving),
	.torque_cmd(torque_cmd), .amp_enable(amp_enable), .integ_enable(integ_enable),
	.axis_stop(axis_stop), .fol_fault(fol_fault), .error_trap(error_trap));

// ---- test/som_monitor_tb.sv ----
// Self-checking bench for the servo overload monitor.
// Assumes som_pkg, the amplifier model and a short overload sample.
`timescale 1ns/10ps
module som_monitor_tb;
	import som_pkg::*;
	logic             clk = 1'b0;
	logic             rst_b = 1'b0;
	logic             psel = 1'b0;
	logic             penable = 1'b0;
	logic             pwrite = 1'b0;
	logic             profile_moving = 1'b0;
	logic [7:0]       paddr = 8'h00;
	logic [31:0]      pwdata = 32'h0;
	logic [31:0]      lag = 32'h0;
	logic [31:0]      lim;
	logic [31:0]      prdata;
	logic             pready, pslverr, error_trap;
	logic [7:0][17:0] torque_req = '0;
	logic [7:0][31:0] cmd_pos = '0;
	logic [7:0][31:0] enc_pos_pin;
	logic [7:0][15:0] torque_cmd;
	logic [7:0]       amp_enable, integ_enable, axis_stop, fol_fault;
	logic [32:0]      exp_q[$];
	int               err_count = 0;
	int               total_checks = 0;

	always #5 clk = ~clk;

	som_monitor #(.SAMPLE_CYCLES_P(8)) dut (.clk(clk), .rst_b(rst_b), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .torque_req(torque_req),
		.cmd_pos(cmd_pos), .enc_pos_pin(enc_pos_pin), .profile_moving(profile_moving),
		.torque_cmd(torque_cmd), .amp_enable(amp_enable), .integ_enable(integ_enable),
		.axis_stop(axis_stop), .fol_fault(fol_fault), .error_trap(error_trap));
	som_amp_model amp (.clk(clk), .rst_b(rst_b), .amp_enable(amp_enable),
		.cmd_pos(cmd_pos), .lag(lag), .enc_pos_pin(enc_pos_pin));

	task chk(input string n, input logic [32:0] e, input logic [32:0] s);
		total_checks++;
		if (s !== e) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e, input logic er);
		exp_q.push_back({er, e});
		apb(1'b0, a, 32'h0);
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task report_and_stop;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Oldest noted read result against what the slave returns
	always @(posedge clk) begin
		if (psel && penable && !pwrite && pready === 1'b1)
			chk("apb_read", exp_q.pop_front(), {pslverr, prdata});
	end

	initial begin
		#300000;
		err_count++;
		report_and_stop();
	end

	initial begin
		void'($urandom(32'hb922));
		foreach (cmd_pos[i]) cmd_pos[i] = $urandom;
		lim = $urandom;
		cyc(12);
		rst_b <= 1'b1;
		rd(REG_OVL_TIME, 32'h0bb8, 1'b0);
		rd(REG_TASK_MASK, 32'hff, 1'b0);
		rd(8'h1c, 32'h0, 1'b1);
		$display("test reset done");
		apb(1'b1, 8'h20, lim);
		apb(1'b1, 8'h3c, ~lim);
		rd(8'h20, lim, 1'b0);
		rd(8'h3c, ~lim, 1'b0);
		apb(1'b1, 8'h44, 32'h64);
		apb(1'b1, REG_BULK_CTRL, 32'h0);
		rd(8'h24, 32'h64, 1'b0);
		rd(8'h20, lim, 1'b0);
		$display("test limits done");
		torque_req[0] <= 18'h1ffff;
		cyc(3);
		chk("torque_cmd", 16'h7fff, torque_cmd[0]);
		torque_req[0] <= 18'h20000;
		cyc(3);
		chk("torque_cmd", 16'h8001, torque_cmd[0]);
		torque_req[0] <= 18'h01234;
		cyc(3);
		chk("torque_cmd", 16'h1234, torque_cmd[0]);
		torque_req[0] <= 18'h0;
		$display("test clamp done");
		apb(1'b1, 8'h20, 32'd100);
		apb(1'b1, REG_INTEG_OPT, 32'h1);
		lag <= 32'd50;
		profile_moving <= 1'b1;
		cyc(6);
		chk("fol_fault", 1'b0, fol_fault[0]);
		chk("integ_enable", 1'b0, integ_enable[0]);
		profile_moving <= 1'b0;
		lag <= 32'hffffff38;
		cyc(6);
		chk("fol_fault", 1'b0, fol_fault[0]);
		chk("integ_enable", 1'b1, integ_enable[0]);
		profile_moving <= 1'b1;
		cyc(6);
		chk("fol_fault", 1'b1, fol_fault[0]);
		profile_moving <= 1'b0;
		$display("test following done");
		apb(1'b1, REG_OVL_TIME, 32'h0);
		torque_req[2] <= 18'h0ffff;
		cyc(200);
		chk("amp_enable", 8'hff, amp_enable);
		torque_req[2] <= 18'h04000;
		apb(1'b1, REG_OVL_TIME, 32'h3);
		cyc(200);
		chk("amp_enable", 8'hff, amp_enable);
		torque_req[2] <= 18'h0ffff;
		cyc(20);
		chk("amp_enable", 8'hff, amp_enable);
		cyc(40);
		chk("amp_enable", 8'hfb, amp_enable);
		chk("error_trap", 1'b1, error_trap);
		chk("axis_stop", 8'hff, axis_stop);
		chk("torque_cmd", 16'h0, torque_cmd[2]);
		rd(REG_ERR_CODE, 32'h31a, 1'b0);
		rd(REG_ERR_AXIS, 32'h3, 1'b0);
		torque_req[2] <= 18'h0;
		apb(1'b1, REG_ERR_CODE, 32'h0);
		cyc(3);
		chk("error_trap", 1'b0, error_trap);
		chk("amp_enable", 8'hff, amp_enable);
		rd(REG_ERR_CODE, 32'h0, 1'b0);
		$display("test overload done");
		cyc(4);
		report_and_stop();
	end
endmodule
